// file: hw/asr_pkg.sv
//
// Contract
// - falling chip select takes the data pin out of high impedance quickly
// - data pin stays high impedance whenever chip select is high; here it is released only after the chip select sync delay
// - after chip select falls, drive result bits until the lsb is shown
// - result goes out msb first, then each lower bit in turn
// - after the first bit, each serial clock rising edge shows the next
// - bits stand stable at falling edges; host captures on falling edges
// - data pin returns to high impedance after the 17th rising edge
// - with fewer edges, chip select rising returns pin to high impedance
// - the result word carried on the serial pin is 16 bits
// - conversion is timed internally, not by sclk, within 2.94 us
//
package asr_pkg;

  // ==========================================================
  // widths
  localparam int WORD_W = 16;
  localparam int EDGE_W = 5;
  localparam int CONV_CNT_W = 9;

  typedef logic [WORD_W-1:0] asr_word_t;
  typedef logic [EDGE_W-1:0] asr_edge_t;
  typedef logic [CONV_CNT_W-1:0] asr_conv_cnt_t;

  // ==========================================================
  // frame positions
  localparam logic [3:0] MSB_IDX = 4'hF;
  localparam asr_edge_t LAST_BIT_EDGE = 5'h0F;
  localparam asr_edge_t RELEASE_EDGE = 5'h11;
  localparam asr_word_t RESULT_RESET = 16'h0000;

  // ==========================================================
  // timing
  localparam int CONV_MAX_NS = 2940;
  localparam int REF_CLK_MHZ = 125;
  localparam int CONV_CYCLES = (CONV_MAX_NS * REF_CLK_MHZ) / 1000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ASR_IDLE = 2'b00,
    ASR_CONVERT = 2'b01,
    ASR_PEND = 2'b10
  } asr_conv_state_e;

  typedef struct packed {
    logic start;
    asr_word_t code;
  } asr_sample_s;

  typedef struct packed {
    asr_edge_t edge_cnt;
    asr_edge_t edge_gray;
    logic released;
  } asr_link_s;

  typedef struct packed {
    asr_conv_state_e state;
    asr_conv_cnt_t conv_cnt;
    asr_word_t sample;
    asr_word_t word;
    logic ready;
    logic busy;
    logic overrun;
    logic frame_active;
    logic oe;
    logic done_seen;
    logic frame_done;
    logic frame_short;
    asr_edge_t edges_seen;
    logic [15:0] frame_cnt;
  } asr_core_s;

  localparam asr_link_s LINK_RESET = '0;
  localparam asr_core_s CORE_RESET = '0;

endpackage : asr_pkg

// file: hw/asr_sync3.sv
`timescale 1ns/1ps
module asr_sync3 #(
  parameter int P_W = 1,
  parameter logic [P_W-1:0] P_RESET = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [P_W-1:0] i_async,
  output logic [P_W-1:0] o_level
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [P_W-1:0] s1;
    logic [P_W-1:0] s2;
    logic [P_W-1:0] s3;
    logic [P_W-1:0] lvl;
  } asr_sync_s;

  asr_sync_s sync_reg;
  asr_sync_s sync_next;

  // ==========================================================
  // filter: a bit moves only once stages two and three agree
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = i_async;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    for (int i = 0; i < P_W; i++) begin
      if (sync_reg.s2[i] == sync_reg.s3[i]) begin
        sync_next.lvl[i] = sync_reg.s3[i];
      end
    end
    if (!i_reset_n) begin
      sync_next = {P_RESET, P_RESET, P_RESET, P_RESET};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    sync_reg <= sync_next;
  end

  assign o_level = sync_reg.lvl;

endmodule : asr_sync3

// file: hw/asr_readout.sv
`timescale 1ns/1ps
module asr_readout #(
  parameter int P_CONV_CYCLES = asr_pkg::CONV_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire asr_pkg::asr_sample_s i_sample,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  output logic o_serial_result_out,
  output logic o_serial_result_oe,
  output logic o_conv_busy,
  output logic o_result_ready,
  output logic o_conv_overrun,
  output logic o_frame_active,
  output logic o_frame_done,
  output logic o_frame_short,
  output logic [4:0] o_edges_seen,
  output logic [15:0] o_frame_count
);

  // ==========================================================
  // helpers
  function automatic asr_pkg::asr_edge_t bin_to_gray(
    input asr_pkg::asr_edge_t b
  );
    bin_to_gray = b ^ (b >> 1);
  endfunction : bin_to_gray

  function automatic asr_pkg::asr_edge_t gray_to_bin(
    input asr_pkg::asr_edge_t g
  );
    asr_pkg::asr_edge_t b;
    b = '0;
    b[asr_pkg::EDGE_W-1] = g[asr_pkg::EDGE_W-1];
    for (int i = asr_pkg::EDGE_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray_to_bin = b;
  endfunction : gray_to_bin

  // ==========================================================
  // state
  asr_pkg::asr_link_s link_reg;
  asr_pkg::asr_link_s link_next;
  asr_pkg::asr_core_s core_reg;
  asr_pkg::asr_core_s core_next;

  logic cs_n_lvl;
  logic released_lvl;
  asr_pkg::asr_edge_t gray_lvl;
  logic cs_low;
  logic frame_end;
  asr_pkg::asr_edge_t bit_sel;
  logic [3:0] word_idx;

  // ==========================================================
  // link domain
  // the host owns this clock and it may stop between frames, so
  // chip select high clears the counter without any edge
  always_comb begin
    link_next = link_reg;
    if (link_reg.edge_cnt != asr_pkg::RELEASE_EDGE) begin
      link_next.edge_cnt = link_reg.edge_cnt + 5'h01;
    end
    link_next.released =
      (link_next.edge_cnt == asr_pkg::RELEASE_EDGE);
    link_next.edge_gray = bin_to_gray(link_next.edge_cnt);
  end

  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      link_reg <= asr_pkg::LINK_RESET;
    end else begin
      link_reg <= link_next;
    end
  end

  // bit shown: msb before the first edge, one lower per edge,
  // lsb held from the 15th edge until release
  always_comb begin
    bit_sel = link_reg.edge_cnt;
    if (link_reg.edge_cnt > asr_pkg::LAST_BIT_EDGE) begin
      bit_sel = asr_pkg::LAST_BIT_EDGE;
    end
  end

  assign word_idx = asr_pkg::MSB_IDX - bit_sel[3:0];

  // the word is frozen for the whole frame, so this select only
  // moves with the rising-edge counter and is steady at falling
  // edges; the cost is a mux after the counter flops
  assign o_serial_result_out = core_reg.word[word_idx];

  // ==========================================================
  // crossings into the reference domain
  asr_sync3 #(
    .P_W(2),
    .P_RESET(2'h1)
  ) u_sync_ctl (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async({link_reg.released, i_cs_n}),
    .o_level({released_lvl, cs_n_lvl})
  );

  asr_sync3 #(
    .P_W(asr_pkg::EDGE_W),
    .P_RESET(5'h00)
  ) u_sync_edges (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async(link_reg.edge_gray),
    .o_level(gray_lvl)
  );

  assign cs_low = ~cs_n_lvl;
  assign frame_end = core_reg.frame_active & ~cs_low;

  // ==========================================================
  // reference domain
  always_comb begin
    core_next = core_reg;
    core_next.frame_done = 1'b0;
    core_next.frame_short = 1'b0;
    core_next.overrun = 1'b0;
    core_next.frame_active = cs_low;

    // pin driven from a falling select until the 17th edge
    core_next.oe = cs_low & ~released_lvl;

    if (!cs_low) begin
      core_next.done_seen = 1'b0;
    end else if (released_lvl) begin
      core_next.done_seen = 1'b1;
    end
    if (cs_low & released_lvl & ~core_reg.done_seen) begin
      core_next.frame_done = 1'b1;
      core_next.frame_cnt = core_reg.frame_cnt + 16'h0001;
    end
    if (frame_end & ~core_reg.done_seen) begin
      core_next.frame_short = 1'b1;
      core_next.frame_cnt = core_reg.frame_cnt + 16'h0001;
    end
    if (cs_low) begin
      core_next.edges_seen = gray_to_bin(gray_lvl);
    end

    // a frame end consumes the result; a load below wins over it
    if (frame_end) begin
      core_next.ready = 1'b0;
    end

    // conversion runs on this clock only, never on the serial clock
    unique case (core_reg.state)
      asr_pkg::ASR_IDLE: begin
        if (i_sample.start) begin
          core_next.sample = i_sample.code;
          core_next.conv_cnt =
            asr_pkg::asr_conv_cnt_t'(P_CONV_CYCLES - 1);
          core_next.state = asr_pkg::ASR_CONVERT;
        end
      end
      asr_pkg::ASR_CONVERT: begin
        if (core_reg.conv_cnt == '0) begin
          if (!cs_low) begin
            core_next.word = core_reg.sample;
            core_next.ready = 1'b1;
            core_next.state = asr_pkg::ASR_IDLE;
          end else begin
            core_next.state = asr_pkg::ASR_PEND;
          end
        end else begin
          core_next.conv_cnt = core_reg.conv_cnt - 9'h001;
        end
      end
      asr_pkg::ASR_PEND: begin
        // the word must not move under a running frame
        if (!cs_low) begin
          core_next.word = core_reg.sample;
          core_next.ready = 1'b1;
          core_next.state = asr_pkg::ASR_IDLE;
        end
      end
      default: begin
        core_next.state = asr_pkg::ASR_IDLE;
      end
    endcase

    if (i_sample.start && core_reg.state != asr_pkg::ASR_IDLE) begin
      core_next.overrun = 1'b1;
    end
    core_next.busy = (core_next.state != asr_pkg::ASR_IDLE);

    if (!i_reset_n) begin
      core_next = asr_pkg::CORE_RESET;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    core_reg <= core_next;
  end

  // ==========================================================
  // outputs
  assign o_serial_result_oe = core_reg.oe;
  assign o_conv_busy = core_reg.busy;
  assign o_result_ready = core_reg.ready;
  assign o_conv_overrun = core_reg.overrun;
  assign o_frame_active = core_reg.frame_active;
  assign o_frame_done = core_reg.frame_done;
  assign o_frame_short = core_reg.frame_short;
  assign o_edges_seen = core_reg.edges_seen;
  assign o_frame_count = core_reg.frame_cnt;

endmodule : asr_readout

// file: testbench/asr_readout_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module asr_readout_assertions #(
  parameter int P_CONV_CYCLES = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire asr_pkg::asr_sample_s i_sample,
  input wire logic i_cs_n,
  input wire logic o_serial_result_oe,
  input wire logic o_conv_busy,
  input wire logic o_result_ready,
  input wire logic o_conv_overrun,
  input wire logic o_frame_done,
  input wire logic o_frame_short,
  input wire logic [4:0] o_edges_seen
);
  // busy is seen high one cycle after the start edge and low one cycle
  // after the load, so the span between the two samples is the full count
  localparam int C_WAIT = P_CONV_CYCLES;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  property p_cs_drive;
    $fell(i_cs_n) |-> ##[1:6] o_serial_result_oe;
  endproperty
  a_cs_drive: assert property (p_cs_drive)
    else $error("pin not driven after select");
  // cs is an async pin, so allow the sync delay before demanding high-z
  property p_idle_hiz;
    i_cs_n [*8] |-> !o_serial_result_oe;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz)
    else $error("pin driven while deselected");
  property p_done_edges;
    o_frame_done |-> o_edges_seen == 5'h11;
  endproperty
  a_done_edges: assert property (p_done_edges)
    else $error("frame done at wrong edge");
  property p_short_edges;
    o_frame_short |-> o_edges_seen < 5'h11;
  endproperty
  a_short_edges: assert property (p_short_edges)
    else $error("short frame with full edges");
  property p_cs_rise_hiz;
    $rose(i_cs_n) |-> ##[1:6] !o_serial_result_oe;
  endproperty
  a_cs_rise_hiz: assert property (p_cs_rise_hiz)
    else $error("pin not released after select");
  property p_start_busy;
    i_sample.start && !o_conv_busy |=> o_conv_busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start not taken");
  property p_overrun;
    i_sample.start && o_conv_busy |=> o_conv_overrun;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");
  property p_conv_time;
    $rose(o_conv_busy) && i_cs_n |->
      ##[C_WAIT:C_WAIT] (!o_conv_busy && o_result_ready);
  endproperty
  a_conv_time: assert property (p_conv_time)
    else $error("conversion time wrong");
endmodule : asr_readout_assertions

// file: testbench/asr_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host serial port, sclk idles high and stands still off-frame
module asr_host_model (
  input wire logic i_serial_result_out,
  input wire logic i_serial_result_oe,
  output logic o_cs_n,
  output logic o_sclk
);
  logic last_bit = 1'b0;
  logic line;
  // a released pin shows the inverse of its last level, never a held bit
  always @(i_serial_result_out or i_serial_result_oe) begin
    if (i_serial_result_oe) last_bit = i_serial_result_out;
  end
  assign line = i_serial_result_oe ? i_serial_result_out : ~last_bit;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
  end
  task automatic read_frame(input int n_edges, output logic [15:0] word);
    word = 16'h0000;
    #7;
    o_cs_n = 1'b0;
    #60;
    for (int k = 0; k < n_edges; k++) begin
      o_sclk = 1'b0;
      if (k < 16) word = {word[14:0], line};
      #15;
      o_sclk = 1'b1;
      #15;
    end
    #60;
    o_cs_n = 1'b1;
  endtask : read_frame
endmodule : asr_host_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// top bench
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  asr_pkg::asr_sample_s i_sample = '0;
  logic cs_n, sclk, serial_result_out, oe, busy, ready, ovr, fact, fdone, fshort;
  logic [4:0] edges;
  logic [15:0] fcount;
  logic [15:0] word;
  logic [15:0] exp_q[$];
  int fail_count = 0;
  int compares = 0;
  int n_frames = 0;
  int n_done = 0;
  int n_short = 0;
  int n_active = 0;
  int exp_done = 0;
  int exp_short = 0;
  always #4 i_ref_clk = ~i_ref_clk;
  // pulses stand one ref cycle, so the falling edge sees each exactly once
  always @(negedge i_ref_clk) begin
    if (fdone === 1'b1) n_done++;
    if (fshort === 1'b1) n_short++;
    if (fact === 1'b1) n_active++;
  end
  asr_readout #(.P_CONV_CYCLES(8)) u_dut (.i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n), .i_sample(i_sample), .i_sclk(sclk),
    .i_cs_n(cs_n), .o_serial_result_out(serial_result_out), .o_serial_result_oe(oe),
    .o_conv_busy(busy), .o_result_ready(ready), .o_conv_overrun(ovr),
    .o_frame_active(fact), .o_frame_done(fdone), .o_frame_short(fshort),
    .o_edges_seen(edges), .o_frame_count(fcount));
  asr_host_model u_host (.i_serial_result_out(serial_result_out),
    .i_serial_result_oe(oe), .o_cs_n(cs_n), .o_sclk(sclk));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // twice: a second start while busy must be refused, word unchanged
  task automatic convert(input logic [15:0] code, input bit twice);
    @(negedge i_ref_clk);
    i_sample <= '{start: 1'b1, code: code};
    exp_q.push_back(code);
    @(negedge i_ref_clk);
    if (twice) i_sample.code <= ~code;
    else i_sample.start <= 1'b0;
    @(negedge i_ref_clk);
    // the refusal pulse stands only in the cycle after the second start
    check(ovr, twice);
    i_sample.start <= 1'b0;
    for (int k = 0; k < 20 && busy !== 1'b0; k++) @(negedge i_ref_clk);
    check(ready, 1'b1);
  endtask : convert
  initial begin
    logic [15:0] code;
    int n_e;
    int act0;
    code = $urandom(32'h8D40C8A0);
    repeat (10) @(negedge i_ref_clk);
    i_reset_n <= 1'b1;
    repeat (6) @(negedge i_ref_clk);
    check(oe, 1'b0);
    check(busy, 1'b0);
    for (int i = 0; i < 6; i++) begin
      code = (i == 1) ? 16'h8001 : 16'($urandom());
      // one frame runs past the 17th edge: extra edges must be ignored
      n_e = (i % 2) ? 16 : ((i == 4) ? 18 : 17);
      convert(code, i == 2);
      act0 = n_active;
      u_host.read_frame(n_e, word);
      n_frames++;
      if (n_e < 17) exp_short++;
      else exp_done++;
      repeat (8) @(negedge i_ref_clk);
      check(word, exp_q.pop_front());
      check(oe, 1'b0);
      check(edges, (n_e > 17) ? 17 : n_e);
      check(fcount, n_frames);
      check(ready, 1'b0);
      check(fact, 1'b0);
      check(n_active > act0, 1'b1);
      check(n_done, exp_done);
      check(n_short, exp_short);
      $display("test %0d done", i);
    end
    final_report();
  end
  // whole run needs about 5 us; far longer means a hang
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
endmodule : tb_top
bind asr_readout asr_readout_assertions #(.P_CONV_CYCLES(P_CONV_CYCLES))
  u_chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
  .i_sample(i_sample), .i_cs_n(i_cs_n),
  .o_serial_result_oe(o_serial_result_oe), .o_conv_busy(o_conv_busy),
  .o_result_ready(o_result_ready), .o_conv_overrun(o_conv_overrun),
  .o_frame_done(o_frame_done), .o_frame_short(o_frame_short),
  .o_edges_seen(o_edges_seen));
